/* File: hw/flash_host_ctrl.sv */
// APB-controlled host that runs bus operations on an asynchronous parallel NOR flash
//
// Functional notes
// - Array read drives chip select and output enable low, write enable high, reset high.
// - Every command or data write pulses write enable low under chip select, output enable high.
// - Address bits 20..0 in word mode, plus the byte-address bit in byte mode.
// - Program data is a byte or a word according to width-select.
// - In unlock-bypass mode a program takes two write cycles instead of four.
// - Reset at protect voltage with A1 high, A0 low: A6 low protects, high unprotects.
`default_nettype none
module flash_host_ctrl (
   // APB slave
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic [7:0]                  paddr,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [31:0]                 pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Flash pins
   output flash_host_pkg::flash_pins_t      pins,
   input  wire logic [15:0]                 dq_in
);
   import flash_host_pkg::*;

   typedef enum {st_idle, st_setup, st_strobe, st_hold, st_rst_low, st_rst_rec} state_t;

   state_t            state_r;
   state_t            state_nxt;
   flash_op_t         op_r;
   flash_op_t         op_nxt;
   logic [CNT_W-1:0]  cnt_r;
   logic [CNT_W-1:0]  cnt_nxt;
   logic              capture;
   logic              finish;
   logic              byte_mode_r;
   accel_level_t      accel_r;
   logic              temp_unprot_r;
   logic [21:0]       addr_r;
   logic [15:0]       wdata_r;
   logic [15:0]       rdata_r;
   logic              done_r;
   logic              reject_r;
   logic [15:0]       dq_s1_r;
   logic [15:0]       dq_s2_r;
   logic [31:0]       prdata_r;
   logic              pready_r;
   logic              pslverr_r;
   flash_pins_t       pins_r;
   flash_pins_t       pins_nxt;
   logic              busy;
   logic              wr_en;
   logic              mapped;
   logic              start;
   logic              cfg_write;
   logic [31:0]       rd_mux;

   assign busy   = state_r != st_idle;
   assign wr_en  = psel & penable & pwrite & pready_r;
   assign mapped = paddr == OFS_CTRL || paddr == OFS_ADDR || paddr == OFS_WDATA ||
                   paddr == OFS_CMD || paddr == OFS_RDATA || paddr == OFS_STATUS;
   // Configuration is frozen during an operation so pins never change mid-cycle
   assign cfg_write = wr_en & ~busy;
   assign start  = cfg_write & paddr == OFS_CMD & pwdata[2:0] <= OP_LAST;

   // Zero-wait slave: answer is prepared in the setup cycle, ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= psel & ~penable;
         prdata_r  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
         pslverr_r <= psel & ~penable & ~mapped;
      end
   end

   always_comb begin
      case (paddr)
         OFS_CTRL:   rd_mux = {28'h0000000, temp_unprot_r, accel_r, byte_mode_r};
         OFS_ADDR:   rd_mux = {10'h000, addr_r};
         OFS_WDATA:  rd_mux = {16'h0000, wdata_r};
         OFS_CMD:    rd_mux = {29'h00000000, op_r};
         OFS_RDATA:  rd_mux = {16'h0000, rdata_r};
         OFS_STATUS: rd_mux = {29'h00000000, reject_r, done_r, busy};
         default:    rd_mux = 32'h00000000;
      endcase
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_mode_r   <= 1'b0;
         accel_r       <= pa_low;
         temp_unprot_r <= 1'b0;
      end else if (cfg_write && paddr == OFS_CTRL) begin
         byte_mode_r   <= pwdata[CTRL_BYTE_BIT];
         // The accel level unprotects every sector; undefined code falls back to low
         accel_r       <= (pwdata[CTRL_ACCEL_LSB+1 -: 2] == 2'h3) ? pa_low :
                          accel_level_t'(pwdata[CTRL_ACCEL_LSB+1 -: 2]);
         temp_unprot_r <= pwdata[CTRL_TEMP_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r  <= ADDR_RST;
         wdata_r <= WDATA_RST;
      end else begin
         if (cfg_write && paddr == OFS_ADDR) begin
            addr_r <= pwdata[21:0];
         end
         if (cfg_write && paddr == OFS_WDATA) begin
            wdata_r <= pwdata[15:0];
         end
      end
   end

   // Sticky flags, cleared by writing one; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_r   <= 1'b0;
         reject_r <= 1'b0;
      end else begin
         done_r   <= finish |
                     (done_r & ~(wr_en & paddr == OFS_STATUS & pwdata[STAT_DONE_BIT]));
         reject_r <= (wr_en & busy & paddr != OFS_STATUS) |
                     (wr_en & ~busy & paddr == OFS_CMD & pwdata[2:0] > OP_LAST) |
                     (reject_r & ~(wr_en & paddr == OFS_STATUS & pwdata[STAT_REJECT_BIT]));
      end
   end

   // Data pins come from another timing domain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_s1_r <= 16'h0000;
         dq_s2_r <= 16'h0000;
      end else begin
         dq_s1_r <= dq_in;
         dq_s2_r <= dq_s1_r;
      end
   end

   // Operation sequencer
   always_comb begin
      state_nxt = state_r;
      op_nxt    = op_r;
      cnt_nxt   = cnt_r;
      capture   = 1'b0;
      finish    = 1'b0;
      case (state_r)
         st_idle: begin
            if (start) begin
               op_nxt = flash_op_t'(pwdata[2:0]);
               if (op_nxt == op_reset) begin
                  state_nxt = st_rst_low;
                  cnt_nxt   = RP_CYC;
               end else begin
                  state_nxt = st_setup;
                  cnt_nxt   = (op_nxt == op_read) ? RD_CYC : SETUP_CYC;
               end
            end
         end
         st_setup: begin
            if (cnt_r == CNT_W'(1)) begin
               if (op_r == op_read) begin
                  capture   = 1'b1;
                  state_nxt = st_hold;
                  cnt_nxt   = HOLD_CYC;
               end else begin
                  // One CMD write is one bus write cycle; software strings them into sequences
                  state_nxt = st_strobe;
                  cnt_nxt   = WP_CYC;
               end
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         st_strobe: begin
            if (cnt_r == CNT_W'(1)) begin
               state_nxt = st_hold;
               cnt_nxt   = HOLD_CYC;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         st_hold: begin
            if (cnt_r == CNT_W'(1)) begin
               state_nxt = st_idle;
               finish    = 1'b1;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         st_rst_low: begin
            if (cnt_r == CNT_W'(1)) begin
               state_nxt = st_rst_rec;
               cnt_nxt   = RH_CYC;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         st_rst_rec: begin
            // Device is back in array read, so the next read needs no command
            if (cnt_r == CNT_W'(1)) begin
               state_nxt = st_idle;
               finish    = 1'b1;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         default: begin
            state_nxt = st_idle;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= st_idle;
         op_r    <= op_read;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         op_r    <= op_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_r <= 16'h0000;
      end else if (capture) begin
         rdata_r <= byte_mode_r ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
      end
   end

   // Pin levels for the coming cycle; registered so every pin is glitch free
   always_comb begin
      pins_nxt                          = PINS_RST;
      pins_nxt.reset_n                  = 1'b1;
      pins_nxt.byte_sel_n               = ~byte_mode_r;
      pins_nxt.protect_accel_pin        = accel_r;
      pins_nxt.reset_at_protect_voltage = temp_unprot_r;
      pins_nxt.addr                     = addr_r[20:0];
      case (state_nxt)
         st_setup, st_strobe, st_hold: begin
            pins_nxt.chip_sel_n = 1'b0;
            if (byte_mode_r) begin
               pins_nxt.dq_out[15] = addr_r[ADDR_LSB_BIT];
               pins_nxt.dq_oe[15]  = 1'b1;
            end
            if (op_nxt == op_read) begin
               // A read never strobes write enable, so the command register is left alone
               pins_nxt.out_en_n = state_nxt == st_hold;
            end else begin
               // Write enable only ever falls inside chip select
               pins_nxt.write_en_n = state_nxt != st_strobe;
               pins_nxt.dq_out     = byte_mode_r ?
                  {pins_nxt.dq_out[15], 7'h00, wdata_r[7:0]} : wdata_r;
               pins_nxt.dq_oe      = byte_mode_r ? DQ_OE_BYTE : DQ_OE_WORD;
            end
            if (op_nxt == op_protect || op_nxt == op_unprotect) begin
               pins_nxt.reset_at_protect_voltage = 1'b1;
               pins_nxt.addr[A6_BIT] = op_nxt == op_unprotect;
               pins_nxt.addr[A1_BIT] = 1'b1;
               pins_nxt.addr[A0_BIT] = 1'b0;
            end
         end
         st_rst_low: begin
            pins_nxt.reset_n                  = 1'b0;
            pins_nxt.reset_at_protect_voltage = 1'b0;
         end
         default: begin
            pins_nxt.chip_sel_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_r <= PINS_RST;
      end else begin
         pins_r <= pins_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign pins    = pins_r;
endmodule : flash_host_ctrl
`default_nettype wire

/* File: hw/flash_host_pkg.sv */
// Shared constants, types and pin bundle for the parallel flash host controller
`default_nettype none
package flash_host_pkg;
   // Register offsets (APB byte addresses)
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_WDATA  = 8'h08;
   localparam logic [7:0] OFS_CMD    = 8'h0c;
   localparam logic [7:0] OFS_RDATA  = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   // Field positions
   localparam int unsigned CTRL_BYTE_BIT   = 0;
   localparam int unsigned CTRL_ACCEL_LSB  = 1;
   localparam int unsigned CTRL_TEMP_BIT   = 3;
   localparam int unsigned ADDR_LSB_BIT    = 21;
   localparam int unsigned STAT_BUSY_BIT   = 0;
   localparam int unsigned STAT_DONE_BIT   = 1;
   localparam int unsigned STAT_REJECT_BIT = 2;
   localparam int unsigned A6_BIT          = 6;
   localparam int unsigned A1_BIT          = 1;
   localparam int unsigned A0_BIT          = 0;
   // Reset values
   localparam logic [21:0] ADDR_RST  = 22'h000000;
   localparam logic [15:0] WDATA_RST = 16'h0000;
   // Data lanes driven in each width mode, bit 15 carries the byte address in byte mode
   localparam logic [15:0] DQ_OE_WORD = 16'hffff;
   localparam logic [15:0] DQ_OE_BYTE = 16'h80ff;
   // Timing in ns and derived cycle counts at the pclk rate
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SYNC_STAGES   = 2;
   localparam int unsigned T_ACC_NS      = 70;
   localparam int unsigned T_SETUP_NS    = 20;
   localparam int unsigned T_WP_NS       = 35;
   localparam int unsigned T_HOLD_NS     = 20;
   localparam int unsigned T_RP_NS       = 500;
   localparam int unsigned T_RH_NS       = 50;
   localparam int unsigned CNT_W         = 8;
   localparam logic [CNT_W-1:0] RD_CYC   =
      CNT_W'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES + 1);
   localparam logic [CNT_W-1:0] SETUP_CYC =
      CNT_W'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WP_CYC   = CNT_W'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] HOLD_CYC =
      CNT_W'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RP_CYC   = CNT_W'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RH_CYC   = CNT_W'((T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {op_read, op_write, op_reset, op_protect, op_unprotect} flash_op_t;
   localparam logic [2:0] OP_LAST = 3'h4;
   // Level requested on protect_accel_pin
   typedef enum logic [1:0] {pa_low, pa_high, pa_accel} accel_level_t;

   typedef struct packed {
      logic         chip_sel_n;
      logic         out_en_n;
      logic         write_en_n;
      logic         reset_n;
      logic         reset_at_protect_voltage;
      logic         byte_sel_n;
      accel_level_t protect_accel_pin;
      logic [20:0]  addr;
      logic [15:0]  dq_out;
      logic [15:0]  dq_oe;
   } flash_pins_t;

   localparam flash_pins_t PINS_RST = '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1,
      reset_n: 1'b0, reset_at_protect_voltage: 1'b0, byte_sel_n: 1'b1,
      protect_accel_pin: pa_low, addr: 21'h000000, dq_out: 16'h0000, dq_oe: 16'h0000};
endpackage : flash_host_pkg
`default_nettype wire

/* File: testbench/flash_dev_model.sv */
// Behavioural parallel flash device facing the host controller pins
`default_nettype none
module flash_dev_model (
   // Flash pins from the host
   input  wire flash_host_pkg::flash_pins_t pins,
   output logic [15:0]                     dq_in
);
   timeunit 1ns;
   timeprecision 1ns;
   import flash_host_pkg::*;
   logic [15:0] mem [0:15];
   logic [15:0] last_q, rd_val, cmd_data;
   logic [20:0] cmd_addr;
   logic        cmd_lsb, prot_seen, rd_en, lsb;
   int          aborts, writes;
   // Array read from power-up: no command before the first read
   initial begin
      for (int i = 0; i < 16; i++)
         mem[i] = 16'hc3a0 ^ 16'(i);
      last_q = 16'h0000;
      aborts = 0;
      writes = 0;
   end
   assign lsb    = pins.dq_out[15];
   assign rd_en  = !pins.chip_sel_n && !pins.out_en_n && pins.write_en_n && pins.reset_n;
   assign rd_val = pins.byte_sel_n ? mem[pins.addr[3:0]] : {8'h00, lsb ?
                   mem[pins.addr[3:0]][15:8] : mem[pins.addr[3:0]][7:0]};
   // Released lanes show the inverse of the last value, so a stale sample cannot pass
   always @(negedge rd_en) last_q = rd_val;
   always_comb begin
      for (int i = 0; i < 16; i++)
         dq_in[i] = pins.dq_oe[i] ? pins.dq_out[i] :
                    (rd_en && (pins.byte_sel_n || i < 8)) ? rd_val[i] : ~last_q[i];
   end
   // Latch on the trailing write edge; ignored while deselected or in reset
   always @(posedge pins.write_en_n) begin
      if (!pins.chip_sel_n && pins.reset_n) begin
         writes++;
         cmd_addr  = pins.addr;
         cmd_data  = dq_in;
         cmd_lsb   = lsb;
         prot_seen = pins.reset_at_protect_voltage;
         if (pins.byte_sel_n)
            mem[pins.addr[3:0]] = dq_in;
         else if (lsb)
            mem[pins.addr[3:0]][15:8] = dq_in[7:0];
         else
            mem[pins.addr[3:0]][7:0] = dq_in[7:0];
      end
   end
   always @(negedge pins.reset_n) aborts++;
endmodule : flash_dev_model
`default_nettype wire

/* File: testbench/flash_host_props.sv */
// Concurrent checks on the flash host controller ports
`default_nettype none
module flash_host_props (
   // APB
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic [31:0]                 prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   // Flash pins
   input wire flash_host_pkg::flash_pins_t pins
);
   import flash_host_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_we_needs_cs: assert property (!pins.write_en_n |-> !pins.chip_sel_n)
      else $error("write enable low while deselected");
   a_write_oe_high: assert property (!pins.write_en_n |-> pins.out_en_n && pins.reset_n)
      else $error("write cycle without output enable high");
   a_read_no_drive: assert property (!pins.out_en_n |-> pins.dq_oe[14:0] == 15'h0000 &&
      pins.dq_oe[15] == !pins.byte_sel_n)
      else $error("host drives data during read");
   a_read_levels: assert property (!pins.out_en_n |-> !pins.chip_sel_n && pins.write_en_n)
      else $error("read without chip select or with write enable");
   a_byte_lanes: assert property (pins.dq_oe != 0 && !pins.byte_sel_n |->
      pins.dq_oe inside {16'h8000, 16'h80ff})
      else $error("wrong lanes in byte mode");
   a_word_lanes: assert property (pins.dq_oe != 0 && pins.byte_sel_n |-> pins.dq_oe == 16'hffff)
      else $error("wrong lanes in word mode");
   a_read_hold: assert property ($fell(pins.out_en_n) |-> !pins.out_en_n [*8])
      else $error("read strobe too short");
   a_reset_pulse: assert property ($fell(pins.reset_n) |-> !pins.reset_n [*8])
      else $error("reset pulse too short");
   a_ready_setup: assert property (psel && !penable |=> pready && psel && penable)
      else $error("no ready after setup");
   a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error without ready or with data");
   c_read: cover property ($fell(pins.out_en_n));
   c_write: cover property ($fell(pins.write_en_n));
   c_reset: cover property ($fell(pins.reset_n));
endmodule : flash_host_props
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the flash host controller
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_host_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr  = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, e;
   flash_pins_t pins;
   logic [15:0] dq_in;
   int          errors = 0, compares = 0, n0;
   always #5 pclk = ~pclk;
   flash_host_ctrl u_flash_host_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pins(pins), .dq_in(dq_in));
   flash_dev_model u_flash_dev_model (.pins(pins), .dq_in(dq_in));
   task automatic finish_test();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   // One idle cycle after each transfer keeps psel from being assigned twice in a step
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] rq, output logic re);
      int n;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         errors++;
         finish_test();
      end
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] rq);
      apb(a, 1'b0, 32'h0, rq, e);
   endtask : rd
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         rd(OFS_STATUS, q);
         n++;
      end while (q[STAT_DONE_BIT] !== 1'b1 && n < 100);
      chk(q[STAT_BUSY_BIT], 32'h0);
      chk(32'({pins.chip_sel_n, pins.dq_oe}), 32'h10000);
      wr(OFS_STATUS, 32'h6);
      if (n >= 100) begin
         errors++;
         finish_test();
      end
   endtask : wait_done
   task automatic op(input logic [31:0] c);
      wr(OFS_CMD, c);
      wait_done();
   endtask : op
   task automatic rd_at(input logic [31:0] a, input logic [31:0] x);
      wr(OFS_ADDR, a);
      op(32'h0);
      rd(OFS_RDATA, q);
      chk(q, x);
   endtask : rd_at
   task automatic t_word();
      rd_at(32'h3, 32'hc3a3);
      wr(OFS_ADDR, 32'h5);
      wr(OFS_WDATA, 32'hbeef);
      op(32'h1);
      chk(32'(u_flash_dev_model.cmd_addr), 32'h5);
      chk(32'(u_flash_dev_model.cmd_data), 32'hbeef);
      rd_at(32'h5, 32'hbeef);
   endtask : t_word
   task automatic t_byte();
      wr(OFS_CTRL, 32'h1);
      wr(OFS_ADDR, 32'h0020_0006);
      wr(OFS_WDATA, 32'h12a7);
      op(32'h1);
      chk(32'(u_flash_dev_model.cmd_lsb), 32'h1);
      rd_at(32'h0020_0006, 32'ha7);
      rd_at(32'h6, 32'ha6);
      wr(OFS_CTRL, 32'h0);
   endtask : t_byte
   task automatic t_protect();
      wr(OFS_ADDR, 32'h1000ff);
      for (int i = 3; i < 5; i++) begin
         op(32'(i));
         chk(32'(u_flash_dev_model.cmd_addr), (i == 3) ? 32'h1000be : 32'h1000fe);
         chk(32'(u_flash_dev_model.prot_seen), 32'h1);
      end
   endtask : t_protect
   task automatic t_reset();
      n0 = u_flash_dev_model.aborts;
      wr(OFS_ADDR, 32'h7);
      wr(OFS_CMD, 32'h2);
      wr(OFS_ADDR, 32'h9);
      rd(OFS_STATUS, q);
      chk(q & 32'h5, 32'h5);
      wait_done();
      chk(32'(u_flash_dev_model.aborts - n0), 32'h1);
      op(32'h0);
      rd(OFS_RDATA, q);
      chk(q, 32'hc3a7);
   endtask : t_reset
   task automatic t_refuse();
      apb(8'h18, 1'b0, 32'h0, q, e);
      chk({q[30:0], e}, 32'h1);
      wr(OFS_CMD, 32'h7);
      rd(OFS_STATUS, q);
      chk(q, 32'h4);
      wr(OFS_STATUS, 32'h4);
      rd(OFS_STATUS, q);
      chk(q, 32'h0);
   endtask : t_refuse
   task automatic t_pins();
      for (int i = 0; i < 5; i++) begin
         wr(OFS_CTRL, 32'(i << 1));
         // Pins are registered one edge after the register, so look one edge later
         @(posedge pclk);
         chk(32'(pins.protect_accel_pin), (i == 3 || i == 4) ? 32'h0 : 32'(i));
         chk(32'(pins.reset_at_protect_voltage), 32'(i == 4));
      end
      wr(OFS_CTRL, 32'h0);
   endtask : t_pins
   task automatic t_bypass();
      n0 = u_flash_dev_model.writes;
      wr(OFS_ADDR, 32'ha);
      wr(OFS_WDATA, 32'ha0);
      op(32'h1);
      wr(OFS_WDATA, 32'h5a5a);
      op(32'h1);
      chk(32'(u_flash_dev_model.writes - n0), 32'h2);
      rd_at(32'ha, 32'h5a5a);
   endtask : t_bypass
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_word();
      t_byte();
      t_protect();
      t_reset();
      t_refuse();
      t_pins();
      t_bypass();
      finish_test();
   end
endmodule : testbench
bind flash_host_ctrl flash_host_props u_flash_host_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pins(pins));
`default_nettype wire
